// ==== common/rtcpt_pkg.sv ====
// constants, field layout and source encoding of the real-time counter block
// assumes one 250 MHz clock, slow sources sampled as synchronous levels
//
// Function
// - periodic tick timer runs whether or not the counter is enabled.
// - 16-bit counter of prescaled ticks, compared against period and compare values.
// - first count after counter equals compare raises compare flag and event.
// - first count after counter equals period raises overflow flag and event.
// - overflow returns the counter to zero, so it spans zero to period.
// - slow source is crystal, external clock, internal oscillator, or oscillator over 32.
// - selected source passes a 15-bit prescaler before reaching the counter.
// - periodic timer uses the same slow clock, interrupt or level event every n.
// - n is 4 to 32768 for interrupts, 64 to 8192 for events.
// - counting continues in sleep; block can wake or interrupt at intervals.
// - prescaler stopped while both functions off, runs when either is enabled.
// - after first interrupt the periodic output toggles every half period.
// - overflow and compare events last one slow period, same conditions as flags.
package rtcpt_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned RTCPT_AW  = 5;
  localparam int unsigned RTCPT_DW  = 16;
  localparam int unsigned RTCPT_PSW = 15;
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_PIT   = 5'h04;
  localparam logic [4:0] OFS_CNT   = 5'h08;
  localparam logic [4:0] OFS_PER   = 5'h0c;
  localparam logic [4:0] OFS_CMP   = 5'h10;
  localparam logic [4:0] OFS_STAT  = 5'h14;
  localparam logic [4:0] OFS_MASK  = 5'h18;
  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PSC_LSB = 1;
  localparam int unsigned CTRL_SRC_LSB = 5;
  localparam int unsigned PIT_EN_BIT   = 0;
  localparam int unsigned PIT_PER_LSB  = 1;
  localparam logic [3:0]  PIT_PER_MIN  = 4'h1;
  localparam logic [3:0]  PIT_PER_MAX  = 4'he;
  localparam int unsigned IRQ_OVF      = 0;
  localparam int unsigned IRQ_CMP      = 1;
  localparam int unsigned IRQ_PIT      = 2;
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned EVT_N        = 8;
  localparam int unsigned EVT_LSB      = 5;
  localparam logic [4:0]  OSC_DIV_LAST = 5'h1f;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PIT_RST  = 16'h0000;
  localparam logic [15:0] PER_RST  = 16'hffff;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [2:0]  MASK_RST = 3'h0;
  typedef enum logic [1:0] {
    RTCPT_SRC_XTAL   = 2'h0,
    RTCPT_SRC_EXTCLK = 2'h1,
    RTCPT_SRC_OSC    = 2'h2,
    RTCPT_SRC_OSCDIV = 2'h3
  } rtcpt_src_t;
endpackage

// ==== rtl/rtcpt_top.sv ====
// real-time counter with shared prescaler and periodic tick timer
// assumes slow source levels are synchronous to clk and far slower than it
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module rtcpt_top
  import rtcpt_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic [RTCPT_AW-1:0] addr,
  input  wire logic [RTCPT_DW-1:0] wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [RTCPT_DW-1:0] rdata,
  // slow clock sources
  input  wire logic                crystal_osc_level,
  input  wire logic                crystal_pin_one,
  input  wire logic                internal_32k_oscillator,
  // events and interrupt
  output logic                     overflow_evt,
  output logic                     compare_match_evt,
  output logic      [EVT_N-1:0]    periodic_evt,
  output logic                     irq,
  output logic                     wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [RTCPT_AW-1:0] a, input logic [RTCPT_AW-1:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [RTCPT_PSW-1:0] psc_mask(input logic [3:0] p);
    logic [15:0] m;
    m = 16'(16'h0001 << p) - 16'h0001;
    psc_mask = m[RTCPT_PSW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]          ctrl_ff;
  logic [15:0]          pit_ctrl_ff;
  logic [15:0]          per_ff;
  logic [15:0]          cmp_ff;
  logic [15:0]          cnt_ff;
  logic [IRQ_W-1:0]     stat_ff;
  logic [IRQ_W-1:0]     mask_ff;
  logic [RTCPT_PSW-1:0] psc_ff;
  logic [4:0]           osc_div_ff;
  logic                 src_q_ff;
  logic                 osc_q_ff;
  logic                 osc_div_tick_ff;
  logic                 pit_q_ff;
  logic [15:0]          rdata_ff;
  logic                 ovf_evt_ff;
  logic                 cmp_evt_ff;
  logic [EVT_N-1:0]     pit_evt_ff;
  logic                 irq_ff;

  logic                 rtc_en;
  logic                 pit_en;
  logic [3:0]           psel;
  logic [3:0]           pit_sel;
  rtcpt_src_t           src_sel;
  logic                 src_lvl;
  logic                 slow_tick;
  logic                 osc_edge;
  logic                 psc_run;
  logic                 cnt_tick;
  logic                 ovf_cond;
  logic                 cmp_cond;
  logic                 pit_lvl;
  logic                 pit_rise;
  logic [IRQ_W-1:0]     evt_set;
  logic [IRQ_W-1:0]     w1c;

  assign rtc_en  = ctrl_ff[CTRL_EN_BIT];
  assign psel    = ctrl_ff[CTRL_PSC_LSB +: 4];
  assign src_sel = rtcpt_src_t'(ctrl_ff[CTRL_SRC_LSB +: 2]);
  assign pit_en  = pit_ctrl_ff[PIT_EN_BIT];
  assign pit_sel = pit_ctrl_ff[PIT_PER_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // source selection; the divided oscillator is already a tick, not a level
  always_comb begin
    case (src_sel)
      RTCPT_SRC_XTAL:   src_lvl = crystal_osc_level;
      RTCPT_SRC_EXTCLK: src_lvl = crystal_pin_one;
      RTCPT_SRC_OSC:    src_lvl = internal_32k_oscillator;
      RTCPT_SRC_OSCDIV: src_lvl = osc_div_tick_ff;
      default:          src_lvl = 1'b0;
    endcase
  end

  assign osc_edge  = internal_32k_oscillator & ~osc_q_ff;
  assign slow_tick = src_lvl & ~src_q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q_ff <= 1'b0;
      osc_q_ff <= 1'b0;
    end else begin
      src_q_ff <= src_lvl;
      osc_q_ff <= internal_32k_oscillator;
    end
  end

  // oscillator over 32: one-cycle high pulse every 32 oscillator edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_div_ff      <= 5'h00;
      osc_div_tick_ff <= 1'b0;
    end else begin
      osc_div_tick_ff <= osc_edge && (osc_div_ff == OSC_DIV_LAST);
      if (osc_edge) begin
        osc_div_ff <= osc_div_ff + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared prescaler; holds its phase while stopped, so first tick is arbitrary
  assign psc_run  = rtc_en | pit_en;
  assign cnt_tick = slow_tick && rtc_en
                    && ((psc_ff & psc_mask(psel)) == psc_mask(psel));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psc_ff <= '0;
    end else if (psc_run && slow_tick) begin
      psc_ff <= psc_ff + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter; no sleep input, it never stops except by its enable
  assign ovf_cond = cnt_tick && (cnt_ff == per_ff);
  assign cmp_cond = cnt_tick && (cnt_ff == cmp_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
    end else if (ovf_cond) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // events span from their tick to the next slow tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_evt_ff <= 1'b0;
      cmp_evt_ff <= 1'b0;
    end else if (slow_tick) begin
      ovf_evt_ff <= ovf_cond;
      cmp_evt_ff <= cmp_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic tick: period 2^(sel+1) follows prescaler bit sel, half high half low
  assign pit_lvl  = pit_en && (pit_sel >= PIT_PER_MIN) && (pit_sel <= PIT_PER_MAX)
                    && psc_ff[pit_sel];
  assign pit_rise = pit_lvl & ~pit_q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pit_q_ff <= 1'b0;
    end else begin
      pit_q_ff <= pit_lvl;
    end
  end

  // level events divide by 64 up to 8192
  generate
    for (genvar i = 0; i < EVT_N; i++) begin : g_pit_evt
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pit_evt_ff[i] <= 1'b0;
        end else begin
          pit_evt_ff[i] <= pit_en & psc_ff[EVT_LSB + i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff     <= CTRL_RST;
      pit_ctrl_ff <= PIT_RST;
      per_ff      <= PER_RST;
      cmp_ff      <= CMP_RST;
      mask_ff     <= MASK_RST;
    end else if (wr) begin
      if (hit(addr, OFS_CTRL)) ctrl_ff     <= wdata;
      if (hit(addr, OFS_PIT))  pit_ctrl_ff <= wdata;
      if (hit(addr, OFS_PER))  per_ff      <= wdata;
      if (hit(addr, OFS_CMP))  cmp_ff      <= wdata;
      if (hit(addr, OFS_MASK)) mask_ff     <= wdata[IRQ_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  assign evt_set = {pit_rise, cmp_cond, ovf_cond};
  assign w1c     = (wr && hit(addr, OFS_STAT)) ? wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~w1c) | evt_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // counter read is single-clock here, so the fast-bus ratio only bounds tick spacing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (rd) begin
      if (hit(addr, OFS_CTRL))      rdata_ff <= ctrl_ff;
      else if (hit(addr, OFS_PIT))  rdata_ff <= pit_ctrl_ff;
      else if (hit(addr, OFS_CNT))  rdata_ff <= cnt_ff;
      else if (hit(addr, OFS_PER))  rdata_ff <= per_ff;
      else if (hit(addr, OFS_CMP))  rdata_ff <= cmp_ff;
      else if (hit(addr, OFS_STAT)) rdata_ff <= {13'h0000, stat_ff};
      else if (hit(addr, OFS_MASK)) rdata_ff <= {13'h0000, mask_ff};
      else                          rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata             = rdata_ff;
  assign overflow_evt      = ovf_evt_ff;
  assign compare_match_evt = cmp_evt_ff;
  assign periodic_evt      = pit_evt_ff;
  assign irq               = irq_ff;
  assign wake_req          = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wrap_tick;
    cnt_tick && (cnt_ff == per_ff);
  endsequence

  sequence s_step_tick;
    cnt_tick && (cnt_ff != per_ff);
  endsequence

  a_cnt_wrap_zero: assert property (s_wrap_tick |=> cnt_ff == 16'h0000)
    else $error("counter did not return to zero on overflow");

  a_cnt_step_one: assert property (s_step_tick |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not advance by one");

  // another unmasked flag may hold irq high, so only a masked-in overflow is demanded
  a_ovf_flag_set: assert property (s_wrap_tick |=> stat_ff[IRQ_OVF]
                                   ##1 (irq_ff || !$past(mask_ff[IRQ_OVF])))
    else $error("overflow flag or interrupt missing");

  a_cmp_flag_set: assert property (cmp_cond |=> stat_ff[IRQ_CMP])
    else $error("compare flag not set");

  a_cmp_evt_cause: assert property ($rose(cmp_evt_ff) |-> $past(cmp_cond))
    else $error("compare event without its condition");

  a_ovf_evt_end: assert property ($fell(ovf_evt_ff) |-> $past(slow_tick))
    else $error("overflow event ended before a slow period");

  a_psc_held_off: assert property (!rtc_en && !pit_en |=> $stable(psc_ff))
    else $error("prescaler ran while both functions off");

  a_pit_alone_run: assert property (pit_en && !rtc_en && slow_tick
                                    |=> psc_ff == $past(psc_ff) + 15'h0001)
    else $error("prescaler stopped with only the periodic timer on");

  // watches the counter register itself, not the gate term that drives it
  a_psc_gate_tick: assert property ($changed(cnt_ff) |-> $past(slow_tick && rtc_en
                                    && (psc_ff & psc_mask(psel)) == psc_mask(psel)))
    else $error("counter moved off a prescaler boundary");

  a_pit_irq_flag: assert property (pit_rise |=> stat_ff[IRQ_PIT])
    else $error("periodic flag not set");

  a_cnt_read_data: assert property (rd && addr == OFS_CNT && !cnt_tick
                                    |=> rdata == $past(cnt_ff))
    else $error("counter read returned wrong value");

  a_irq_from_mask: assert property ((|(stat_ff & mask_ff)) |=> irq_ff)
    else $error("interrupt not raised for an unmasked flag");

  a_evt_off_quiet: assert property (!pit_en |=> periodic_evt == '0)
    else $error("periodic event active with the timer off");

endmodule // rtcpt_top

// ==== verif/rtcpt_top_tb.sv ====
// self-checking bench for the real-time counter with periodic tick timer
// assumes slow sources are levels driven here, several clk cycles per phase
`timescale 1ns/1ps
module rtcpt_top_tb
  import rtcpt_pkg::*;
;
  logic                clk;
  logic                rst;
  logic [RTCPT_AW-1:0] addr;
  logic [RTCPT_DW-1:0] wdata;
  logic                wr;
  logic                rd;
  logic [RTCPT_DW-1:0] rdata;
  logic [2:0]          lvl;
  logic                ovf_e;
  logic                cmp_e;
  logic [EVT_N-1:0]    pevt;
  logic                irq;
  logic                wake_req;
  logic                pprev;
  int                  errors;
  int                  checks_done;
  int                  rises;

  rtcpt_top DUT (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .crystal_osc_level(lvl[0]), .crystal_pin_one(lvl[1]),
    .internal_32k_oscillator(lvl[2]), .overflow_evt(ovf_e), .compare_match_evt(cmp_e),
    .periodic_evt(pevt), .irq(irq), .wake_req(wake_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // rising edges of the fastest periodic event
  always @(posedge clk) begin
    pprev <= pevt[0];
    if (pevt[0] === 1'b1 && pprev === 1'b0) rises <= rises + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // n slow rising edges on one source pin, slow enough to be seen by the edge register
  task automatic tick(input int pin, input int n);
    repeat (n) begin
      @(posedge clk);
      lvl[pin] <= 1'b1;
      repeat (3) @(posedge clk);
      lvl[pin] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    logic [4:0]  ofs [8];
    logic [15:0] exp [8];
    ofs = '{OFS_CTRL, OFS_PIT, OFS_CNT, OFS_PER, OFS_CMP, OFS_STAT, OFS_MASK, 5'h1c};
    exp = '{CTRL_RST, PIT_RST, 16'h0000, PER_RST, CMP_RST, 16'h0000, {13'h0000, MASK_RST},
            16'h0000};
    for (int i = 0; i < 8; i++) rd_chk("reset value", ofs[i], exp[i]);
    reg_wr(5'h1c, 16'hffff);
    rd_chk("unmapped", 5'h1c, 16'h0000);
    reg_wr(OFS_CNT, 16'h1234);
    rd_chk("cnt read only", OFS_CNT, 16'h0000);
  endtask

  task automatic t_count_seq();
    reg_wr(OFS_PER, 16'h0003);
    reg_wr(OFS_CMP, 16'h0001);
    reg_wr(OFS_CTRL, 16'h0021);
    tick(1, 2);
    check("cmp evt", {15'h0000, cmp_e}, 16'h0001);
    rd_chk("stat cmp", OFS_STAT, 16'h0002);
    rd_chk("cnt two", OFS_CNT, 16'h0002);
    tick(1, 1);
    check("cmp evt end", {15'h0000, cmp_e}, 16'h0000);
    tick(1, 1);
    check("ovf evt", {15'h0000, ovf_e}, 16'h0001);
    rd_chk("stat ovf", OFS_STAT, 16'h0003);
    rd_chk("cnt wrap", OFS_CNT, 16'h0000);
  endtask

  task automatic t_irq();
    reg_wr(OFS_MASK, 16'h0000);
    settle();
    check("irq masked", {15'h0000, irq}, 16'h0000);
    reg_wr(OFS_MASK, 16'h0001);
    settle();
    check("irq ovf", {15'h0000, irq}, 16'h0001);
    check("wake", {15'h0000, wake_req}, 16'h0001);
    reg_wr(OFS_STAT, 16'h0001);
    settle();
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    rd_chk("stat after clear", OFS_STAT, 16'h0002);
    reg_wr(OFS_MASK, 16'h0002);
    settle();
    check("irq cmp", {15'h0000, irq}, 16'h0001);
    reg_wr(OFS_STAT, 16'h0002);
    settle();
    check("irq cmp cleared", {15'h0000, irq}, 16'h0000);
    reg_wr(OFS_MASK, 16'h0000);
  endtask

  // divide by two: any two slow ticks hold exactly one count tick, whatever the phase
  task automatic t_prescale();
    reg_wr(OFS_CTRL, 16'h0023);
    tick(1, 4);
    rd_chk("cnt div2", OFS_CNT, 16'h0002);
  endtask

  task automatic t_pit();
    reg_wr(OFS_CTRL, 16'h0022);
    reg_wr(OFS_STAT, 16'h0007);
    reg_wr(OFS_PIT, 16'h0003);
    tick(1, 4);
    rd_chk("stat pit", OFS_STAT, 16'h0004);
    rd_chk("cnt held", OFS_CNT, 16'h0002);
    rises = 0;
    tick(1, 64);
    check("evt div64 rises", 16'(rises), 16'h0001);
    // period select zero gives no periodic interrupt at all
    reg_wr(OFS_STAT, 16'h0007);
    reg_wr(OFS_PIT, 16'h0001);
    tick(1, 4);
    rd_chk("pit sel zero", OFS_STAT, 16'h0000);
    reg_wr(OFS_PIT, 16'h0000);
    settle();
    check("evt off", {8'h00, pevt}, 16'h0000);
  endtask

  // oscillator divided by 32 goes first, before that pin has ever toggled
  task automatic t_sources();
    int src [4];
    int pin [4];
    int n   [4];
    src = '{3, 0, 1, 2};
    pin = '{2, 0, 1, 2};
    n   = '{32, 1, 1, 1};
    reg_wr(OFS_PER, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      reg_wr(OFS_CTRL, {9'h000, 2'(src[i]), 4'h0, 1'b1});
      tick(pin[i], n[i]);
      reg_wr(OFS_CTRL, 16'h0000);
      rd_chk("cnt per source", OFS_CNT, 16'(3 + i));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    rst         = 1'b1;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    lvl         = 3'h0;
    pprev       = 1'b0;
    errors      = 0;
    checks_done = 0;
    rises       = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_count_seq();
    t_irq();
    t_prescale();
    t_pit();
    t_sources();
    summarize();
  end
endmodule // rtcpt_top_tb
